// *** rtl/txstat_pkg.sv ***
package txstat_pkg;
    // Counter bank layout
    localparam int NUM_CNT = 10;
    localparam int CNT_W = 32;
    localparam int IDX_DEFER = 0;
    localparam int IDX_SINGLE = 1;
    localparam int IDX_MULTI = 2;
    localparam int IDX_TOTAL = 3;
    localparam int IDX_EXCESS = 4;
    localparam int IDX_UNDERRUN = 5;
    localparam int IDX_CRS = 6;
    localparam int IDX_HBEAT = 7;
    localparam int IDX_LATE = 8;
    localparam int IDX_INTERNAL = 9;

    // Collision accounting
    localparam int COLL_W = 5;
    localparam int BITS_W = 14;
    localparam logic [COLL_W-1:0] EXCESS_COLL = 5'h10;
    localparam logic [BITS_W-1:0] LATE_BITS = 14'h0200;

    // APB register map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CNT_BASE = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_CNT_LAST = 12'h034;

    // Control fields and reset values
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_CLR_BIT = 1;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;

    // Status fields
    localparam int STAT_EN_BIT = 0;
    localparam int STAT_LATE_BIT = 1;
    localparam int STAT_COLL_LSB = 8;

    typedef enum logic [2:0]
    {
        APB_IDLE = 3'b001,
        APB_WAIT = 3'b010,
        APB_DONE = 3'b100
    } apb_state_t;
endpackage

// *** rtl/stat_counter.sv ***
`timescale 1ns/1ps
module stat_counter
#(
    parameter int WIDTH = 32
)
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Control
    input wire logic clr_i,
    input wire logic inc_i,
    input wire logic [WIDTH-1:0] amt_i,
    // Value
    output logic [WIDTH-1:0] cnt_o
);
    // Refused at elaboration: narrower counters wrap too soon to be useful
    if (WIDTH < 8)
    begin : g_bad_width
        $error("stat_counter WIDTH too small");
    end

    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    // Increment on a clear cycle still lands, so no event is lost
    always_comb
    begin
        cnt_nxt = clr_i ? '0 : cnt_r;
        if (inc_i)
        begin
            cnt_nxt = cnt_nxt + amt_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_r <= '0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
        end
    end

    assign cnt_o = cnt_r;
endmodule // stat_counter

// *** rtl/tx_event_classify.sv ***
`timescale 1ns/1ps
module tx_event_classify
    import txstat_pkg::*;
(
    // Clock, reset and count enable
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    // Transmit engine events
    input wire logic defer_i,
    input wire logic coll_i,
    input wire logic [txstat_pkg::BITS_W-1:0] coll_bits_i,
    input wire logic pkt_done_i,
    input wire logic pkt_ok_i,
    input wire logic [txstat_pkg::COLL_W-1:0] pkt_coll_cnt_i,
    input wire logic pkt_underrun_i,
    input wire logic pkt_crs_fail_i,
    input wire logic pkt_no_hb_i,
    // Counter strobes
    output logic [txstat_pkg::NUM_CNT-1:0] inc_o,
    output logic [txstat_pkg::COLL_W-1:0] total_add_o,
    output logic late_seen_o
);
    logic late_now;
    logic late_any;
    logic excess;
    logic late_seen_r;
    logic [NUM_CNT-1:0] inc_r;
    logic [NUM_CNT-1:0] inc_nxt;
    logic [COLL_W-1:0] total_add_r;

    assign late_now = coll_i && (coll_bits_i >= LATE_BITS);
    // A late collision in the closing cycle still belongs to this packet
    assign late_any = late_now || late_seen_r;
    assign excess = !pkt_ok_i && (pkt_coll_cnt_i >= EXCESS_COLL);

    always_comb
    begin
        inc_nxt = '0;
        inc_nxt[IDX_DEFER] = defer_i;
        inc_nxt[IDX_LATE] = late_now;
        if (pkt_done_i)
        begin
            inc_nxt[IDX_SINGLE] = pkt_ok_i && (pkt_coll_cnt_i == 5'h01);
            inc_nxt[IDX_MULTI] = pkt_ok_i && (pkt_coll_cnt_i > 5'h01);
            inc_nxt[IDX_TOTAL] = (pkt_coll_cnt_i != 5'h00);
            inc_nxt[IDX_EXCESS] = excess;
            inc_nxt[IDX_UNDERRUN] = !pkt_ok_i && pkt_underrun_i;
            inc_nxt[IDX_CRS] = pkt_crs_fail_i;
            inc_nxt[IDX_HBEAT] = pkt_ok_i && pkt_no_hb_i;
            inc_nxt[IDX_INTERNAL] = !pkt_ok_i && !excess && !pkt_crs_fail_i
                && !late_any;
        end
        if (!enable_i)
        begin
            inc_nxt = '0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            inc_r <= '0;
            total_add_r <= '0;
        end
        else
        begin
            inc_r <= inc_nxt;
            total_add_r <= pkt_coll_cnt_i;
        end
    end

    // The end-of-packet clear wins over the set
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            late_seen_r <= 1'b0;
        end
        else if (late_now && !pkt_done_i)
        begin
            late_seen_r <= 1'b1;
        end
        else if (pkt_done_i)
        begin
            late_seen_r <= 1'b0;
        end
    end

    assign inc_o = inc_r;
    assign total_add_o = total_add_r;
    assign late_seen_o = late_seen_r;
endmodule // tx_event_classify

// *** rtl/tx_stats.sv ***
// Behaviour
// - Count each transmission deferred because carrier sense saw line activity.
// - Count packets sent on second attempt after exactly one collision.
// - Count packets sent successfully after more than one collision.
// - Add each packet's full collision count to the total-collision counter.
// - Count packets that fail after 16 successive collisions.
// - Count transmissions abandoned because the packet buffer underran.
// - Count packets that collide while carrier sense is disabled.
// - Count missing heartbeat; the packet still counts as successful.
// - Count collisions arriving after at least 512 bits were sent.
// - Count other transmit errors: not late, excess or carrier-check.
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module tx_stats
    import txstat_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [txstat_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Transmit engine events, same clock
    input wire logic defer_i,
    input wire logic coll_i,
    input wire logic [txstat_pkg::BITS_W-1:0] coll_bits_i,
    input wire logic pkt_done_i,
    input wire logic pkt_ok_i,
    input wire logic [txstat_pkg::COLL_W-1:0] pkt_coll_cnt_i,
    input wire logic pkt_underrun_i,
    input wire logic pkt_crs_fail_i,
    input wire logic pkt_no_hb_i
);
    import txstat_pkg::*;

    apb_state_t state_r;
    logic count_en_r;
    logic clr_pulse_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [NUM_CNT-1:0] inc;
    logic [COLL_W-1:0] total_add;
    logic late_seen;
    logic [CNT_W-1:0] cnt_w [NUM_CNT];
    logic [31:0] rd_word;
    logic rd_hit;
    logic access;
    logic [COLL_W-1:0] coll_so_far_r;

    tx_event_classify u_classify
    (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .enable_i(count_en_r),
        .defer_i(defer_i),
        .coll_i(coll_i),
        .coll_bits_i(coll_bits_i),
        .pkt_done_i(pkt_done_i),
        .pkt_ok_i(pkt_ok_i),
        .pkt_coll_cnt_i(pkt_coll_cnt_i),
        .pkt_underrun_i(pkt_underrun_i),
        .pkt_crs_fail_i(pkt_crs_fail_i),
        .pkt_no_hb_i(pkt_no_hb_i),
        .inc_o(inc),
        .total_add_o(total_add),
        .late_seen_o(late_seen)
    );

    // One counter per statistic; only the total takes a multi-step amount
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CNT; gi++)
        begin : g_cnt
            logic [CNT_W-1:0] amt;
            assign amt = (gi == IDX_TOTAL) ? {{(CNT_W-COLL_W){1'b0}}, total_add}
                : {{(CNT_W-1){1'b0}}, 1'b1};
            stat_counter #(.WIDTH(CNT_W)) u_cnt
            (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .clr_i(clr_pulse_r),
                .inc_i(inc[gi]),
                .amt_i(amt),
                .cnt_o(cnt_w[gi])
            );
        end
    endgenerate

    // The read index is four bits wide and the bus word is 32 bits
    if (NUM_CNT > 16 || CNT_W != 32)
    begin : g_bad_layout
        $error("tx_stats counter layout not supported");
    end

    // Collisions of the packet in flight, for software visibility
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            coll_so_far_r <= '0;
        end
        else if (pkt_done_i)
        begin
            coll_so_far_r <= '0;
        end
        else if (coll_i && coll_so_far_r != 5'h1F)
        begin
            coll_so_far_r <= coll_so_far_r + 5'h01;
        end
    end

    // Read decode; counters are sampled, never reset by a read
    always_comb
    begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        if (paddr_i == OFF_CTRL)
        begin
            rd_word[CTRL_EN_BIT] = count_en_r;
        end
        else if (paddr_i == OFF_STATUS)
        begin
            rd_word[STAT_EN_BIT] = count_en_r;
            rd_word[STAT_LATE_BIT] = late_seen;
            rd_word[STAT_COLL_LSB +: COLL_W] = coll_so_far_r;
        end
        else if (paddr_i >= OFF_CNT_BASE && paddr_i <= OFF_CNT_LAST
            && paddr_i[1:0] == 2'h0)
        begin
            rd_word = cnt_w[4'((paddr_i - OFF_CNT_BASE) >> 2)];
        end
        else
        begin
            rd_hit = 1'b0;
        end
    end

    assign access = psel_i && penable_i;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= APB_IDLE;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end
        else
        begin
            case (state_r)
                APB_IDLE:
                begin
                    if (access)
                    begin
                        state_r <= APB_DONE;
                        pready_r <= 1'b1;
                        pslverr_r <= !rd_hit || (pwrite_i && paddr_i >= OFF_CNT_BASE);
                        prdata_r <= pwrite_i ? 32'h00000000 : rd_word;
                    end
                end
                APB_DONE:
                begin
                    state_r <= APB_IDLE;
                    pready_r <= 1'b0;
                    pslverr_r <= 1'b0;
                end
                default:
                begin
                    state_r <= APB_IDLE;
                    pready_r <= 1'b0;
                    pslverr_r <= 1'b0;
                end
            endcase
        end
    end

    // Control takes effect at the completing edge only
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            count_en_r <= CTRL_EN_RESET;
            clr_pulse_r <= 1'b0;
        end
        else
        begin
            clr_pulse_r <= 1'b0;
            if (access && pready_r && pwrite_i && paddr_i == OFF_CTRL)
            begin
                count_en_r <= pwdata_i[CTRL_EN_BIT];
                clr_pulse_r <= pwdata_i[CTRL_CLR_BIT];
            end
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;

    // Checks: an event at cycle t moves its counter at edge t+2
    sequence s_pkt_ok(int n);
        pkt_done_i && pkt_ok_i && count_en_r && pkt_coll_cnt_i == n;
    endsequence

    sequence s_pkt_fail;
        pkt_done_i && !pkt_ok_i && count_en_r;
    endsequence

    AST_DEFER: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        defer_i && count_en_r |-> ##2 cnt_w[IDX_DEFER] == $past(cnt_w[IDX_DEFER]) + 32'h1)
        else $error("deferral not counted");

    AST_SINGLE: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        s_pkt_ok(1) |-> ##2 cnt_w[IDX_SINGLE] == $past(cnt_w[IDX_SINGLE]) + 32'h1)
        else $error("single collision not counted");

    AST_MULTI: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        s_pkt_ok(2) |-> ##2 cnt_w[IDX_MULTI] == $past(cnt_w[IDX_MULTI]) + 32'h1
            && cnt_w[IDX_SINGLE] == $past(cnt_w[IDX_SINGLE]))
        else $error("multiple collision miscounted");

    AST_TOTAL: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        pkt_done_i && count_en_r |-> ##2 cnt_w[IDX_TOTAL]
            == $past(cnt_w[IDX_TOTAL]) + {27'h0, $past(pkt_coll_cnt_i, 2)})
        else $error("total collisions wrong");

    AST_EXCESS: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        s_pkt_fail and pkt_coll_cnt_i == 5'h10 |-> ##2
            cnt_w[IDX_EXCESS] == $past(cnt_w[IDX_EXCESS]) + 32'h1
            && cnt_w[IDX_INTERNAL] == $past(cnt_w[IDX_INTERNAL]))
        else $error("excess collision miscounted");

    AST_UNDERRUN: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        s_pkt_fail and pkt_underrun_i |-> ##2
            cnt_w[IDX_UNDERRUN] == $past(cnt_w[IDX_UNDERRUN]) + 32'h1)
        else $error("underrun not counted");

    AST_CRS: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        pkt_done_i && pkt_crs_fail_i && count_en_r |-> ##2
            cnt_w[IDX_CRS] == $past(cnt_w[IDX_CRS]) + 32'h1)
        else $error("carrier check not counted");

    AST_HBEAT: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        s_pkt_ok(0) and pkt_no_hb_i |-> ##2
            cnt_w[IDX_HBEAT] == $past(cnt_w[IDX_HBEAT]) + 32'h1
            && cnt_w[IDX_INTERNAL] == $past(cnt_w[IDX_INTERNAL]))
        else $error("heartbeat miscounted");

    AST_LATE: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        coll_i && count_en_r |-> ##2 cnt_w[IDX_LATE] == $past(cnt_w[IDX_LATE])
            + {31'h0, $past(coll_bits_i, 2) >= 14'h0200})
        else $error("late collision miscounted");

    AST_INTERNAL: assert property (@(posedge mclk_i) disable iff (rst_i || clr_pulse_r)
        s_pkt_fail and pkt_coll_cnt_i == 5'h00 and !pkt_crs_fail_i and !late_seen
            and !coll_i |-> ##2 cnt_w[IDX_INTERNAL] == $past(cnt_w[IDX_INTERNAL]) + 32'h1)
        else $error("internal error not counted");

    AST_READ_STABLE: assert property (@(posedge mclk_i) disable iff (rst_i)
        access && !pwrite_i && !pready_r && !clr_pulse_r && inc == '0
            && paddr_i == OFF_CNT_BASE |=> prdata_o == cnt_w[IDX_DEFER] && pready_o)
        else $error("counter read disturbed");

    // Bus answer: first access cycle, then a single answer cycle
    sequence s_apb_first;
        access && !pready_r;
    endsequence

    sequence s_apb_answer;
        pready_o && state_r == APB_DONE;
    endsequence

    AST_PREADY_PULSE: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_apb_first |=> s_apb_answer ##1 !pready_o)
        else $error("bus answer not a one-cycle pulse");

    AST_SLVERR_QUAL: assert property (@(posedge mclk_i) disable iff (rst_i)
        pslverr_o |-> pready_o)
        else $error("bus error outside an answer");

    AST_CNT_WRITE_REFUSED: assert property (@(posedge mclk_i) disable iff (rst_i)
        s_apb_first and pwrite_i && paddr_i >= OFF_CNT_BASE |=> pslverr_o)
        else $error("counter write not refused");

    AST_READ_NO_SIDE: assert property (@(posedge mclk_i) disable iff (rst_i)
        access && !pwrite_i && inc == '0 && !clr_pulse_r |=>
            cnt_w[IDX_TOTAL] == $past(cnt_w[IDX_TOTAL])
            && cnt_w[IDX_DEFER] == $past(cnt_w[IDX_DEFER]))
        else $error("read changed a counter");

    AST_DISABLED_QUIET: assert property (@(posedge mclk_i) disable iff (rst_i)
        !count_en_r |=> inc == '0)
        else $error("event counted while disabled");

    AST_CLEAR: assert property (@(posedge mclk_i) disable iff (rst_i)
        clr_pulse_r && inc == '0 |=>
            cnt_w[IDX_DEFER] == 32'h0 && cnt_w[IDX_LATE] == 32'h0)
        else $error("clear did not zero the counters");

    AST_LATE_FLAG: assert property (@(posedge mclk_i) disable iff (rst_i)
        coll_i && coll_bits_i >= LATE_BITS && !pkt_done_i |=> late_seen)
        else $error("late collision flag not set");

    AST_COLL_RESTART: assert property (@(posedge mclk_i) disable iff (rst_i)
        pkt_done_i |=> coll_so_far_r == 5'h00)
        else $error("collision tally not restarted");
endmodule // tx_stats

// *** verif/tx_engine_model.sv ***
`timescale 1ns/1ps
module tx_engine_model
    import txstat_pkg::*;
(
    // Clock
    input wire logic mclk_i,
    // Outcome reports
    output logic defer_o,
    output logic coll_o,
    output logic [txstat_pkg::BITS_W-1:0] coll_bits_o,
    output logic pkt_done_o,
    output logic pkt_ok_o,
    output logic [txstat_pkg::COLL_W-1:0] pkt_coll_cnt_o,
    output logic pkt_underrun_o,
    output logic pkt_crs_fail_o,
    output logic pkt_no_hb_o
);
    initial
    begin
        {defer_o, coll_o, pkt_done_o, pkt_ok_o, pkt_underrun_o} = '0;
        {pkt_crs_fail_o, pkt_no_hb_o} = '0;
        coll_bits_o = '0;
        pkt_coll_cnt_o = '0;
    end

    task automatic defer(input int n);
        repeat (n)
        begin
            @(posedge mclk_i);
            defer_o <= 1'b1;
        end
        @(posedge mclk_i);
        defer_o <= 1'b0;
    endtask

    // Qualifiers are scrambled outside their strobe, as a real engine leaves them stale
    task automatic pkt(input logic ok, input logic [COLL_W-1:0] n,
        input logic [BITS_W-1:0] last_bits, input logic urun, input logic crs,
        input logic nohb);
        int i;
        for (i = 0; i < int'(n); i++)
        begin
            @(posedge mclk_i);
            coll_o <= 1'b1;
            coll_bits_o <= (i == int'(n) - 1) ? last_bits : 14'h0040;
        end
        @(posedge mclk_i);
        coll_o <= 1'b0;
        coll_bits_o <= ~coll_bits_o;
        pkt_done_o <= 1'b1;
        pkt_ok_o <= ok;
        pkt_coll_cnt_o <= n;
        pkt_underrun_o <= urun;
        pkt_crs_fail_o <= crs;
        pkt_no_hb_o <= nohb;
        @(posedge mclk_i);
        pkt_done_o <= 1'b0;
        {pkt_ok_o, pkt_underrun_o, pkt_crs_fail_o, pkt_no_hb_o} <= {~ok, ~urun, ~crs, ~nohb};
        pkt_coll_cnt_o <= ~n;
    endtask
endmodule // tx_engine_model

// *** verif/eth_tx_statistics_counters_tb.sv ***
`timescale 1ns/1ps
module eth_tx_statistics_counters_tb;
    import txstat_pkg::*;
    logic mclk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [ADDR_W-1:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic defer_i, coll_i, pkt_done_i, pkt_ok_i, pkt_underrun_i, pkt_crs_fail_i, pkt_no_hb_i;
    logic [BITS_W-1:0] coll_bits_i;
    logic [COLL_W-1:0] pkt_coll_cnt_i;
    logic err;
    logic [CNT_W-1:0] exp_cnt [NUM_CNT];
    int failures = 0, total_checks = 0, cycles = 0;

    tx_stats uut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .defer_i(defer_i), .coll_i(coll_i),
        .coll_bits_i(coll_bits_i), .pkt_done_i(pkt_done_i), .pkt_ok_i(pkt_ok_i),
        .pkt_coll_cnt_i(pkt_coll_cnt_i), .pkt_underrun_i(pkt_underrun_i),
        .pkt_crs_fail_i(pkt_crs_fail_i), .pkt_no_hb_i(pkt_no_hb_i));
    tx_engine_model eng (.mclk_i(mclk_i), .defer_o(defer_i), .coll_o(coll_i),
        .coll_bits_o(coll_bits_i), .pkt_done_o(pkt_done_i), .pkt_ok_o(pkt_ok_i),
        .pkt_coll_cnt_o(pkt_coll_cnt_i), .pkt_underrun_o(pkt_underrun_i),
        .pkt_crs_fail_o(pkt_crs_fail_i), .pkt_no_hb_o(pkt_no_hb_i));

    initial
    begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic end_sim();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Ceiling is tens of times the expected run length
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_sim();
        end
    end

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge mclk_i);
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, wr, a, wd};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        @(posedge mclk_i);
        while (pready_o !== 1'b1)
            @(posedge mclk_i);
        rd = prdata_o;
        err = pslverr_o;
        {psel_i, penable_i} <= 2'b00;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", what, e, g);
            failures++;
        end
    endtask

    task automatic check_counters(input string test);
        int i;
        repeat (3) @(posedge mclk_i);
        for (i = 0; i < NUM_CNT; i++)
        begin
            apb(1'b0, OFF_CNT_BASE + ADDR_W'(4 * i), 32'h0);
            chk($sformatf("counter %0d", i), exp_cnt[i], rd);
        end
        $display("test %s done", test);
    endtask

    initial
    begin
        rst_i = 1'b1;
        {psel_i, penable_i, pwrite_i} = 3'b000;
        paddr_i = '0;
        pwdata_i = '0;
        foreach (exp_cnt[i]) exp_cnt[i] = '0;
        repeat (3) @(posedge mclk_i);
        rst_i <= 1'b0;
        check_counters("reset");
        apb(1'b0, OFF_CTRL, 32'h0);
        chk("enable at reset", 32'h1, {31'h0, rd[CTRL_EN_BIT]});
        eng.defer(2);
        exp_cnt[IDX_DEFER] += 2;
        check_counters("deferral");
        eng.pkt(1'b1, 5'h01, 14'h0040, 1'b0, 1'b0, 1'b0);
        eng.pkt(1'b1, 5'h03, 14'h0040, 1'b0, 1'b0, 1'b0);
        eng.pkt(1'b1, 5'h02, 14'h0040, 1'b0, 1'b0, 1'b0);
        exp_cnt[IDX_SINGLE] += 1;
        exp_cnt[IDX_MULTI] += 2;
        exp_cnt[IDX_TOTAL] += 6;
        check_counters("collided success");
        eng.pkt(1'b0, 5'h10, 14'h0040, 1'b0, 1'b0, 1'b0);
        exp_cnt[IDX_EXCESS] += 1;
        exp_cnt[IDX_TOTAL] += 16;
        check_counters("excess");
        eng.pkt(1'b0, 5'h00, 14'h0000, 1'b1, 1'b0, 1'b0);
        exp_cnt[IDX_UNDERRUN] += 1;
        exp_cnt[IDX_INTERNAL] += 1;
        check_counters("underrun");
        eng.pkt(1'b0, 5'h01, 14'h0040, 1'b0, 1'b1, 1'b0);
        eng.pkt(1'b1, 5'h00, 14'h0000, 1'b0, 1'b0, 1'b1);
        exp_cnt[IDX_CRS] += 1;
        exp_cnt[IDX_TOTAL] += 1;
        exp_cnt[IDX_HBEAT] += 1;
        check_counters("carrier and heartbeat");
        eng.pkt(1'b0, 5'h01, 14'h01FF, 1'b0, 1'b0, 1'b0);
        eng.pkt(1'b0, 5'h02, 14'h0200, 1'b0, 1'b0, 1'b0);
        exp_cnt[IDX_INTERNAL] += 1;
        exp_cnt[IDX_LATE] += 1;
        exp_cnt[IDX_TOTAL] += 3;
        check_counters("late boundary");
        apb(1'b1, OFF_CNT_BASE, 32'h0000_00FF);
        chk("counter write refused", 32'h1, {31'h0, err});
        apb(1'b0, 12'h800, 32'h0);
        chk("unmapped refused", 32'h1, {31'h0, err});
        fork
            eng.defer(3);
            apb(1'b0, OFF_CNT_BASE, 32'h0);
        join
        exp_cnt[IDX_DEFER] += 3;
        check_counters("read while counting");
        apb(1'b1, OFF_CTRL, 32'h0000_0003);
        foreach (exp_cnt[i]) exp_cnt[i] = '0;
        check_counters("clear");
        apb(1'b1, OFF_CTRL, 32'h0000_0000);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status while disabled", 32'h0, rd);
        eng.defer(2);
        eng.pkt(1'b1, 5'h02, 14'h0200, 1'b0, 1'b0, 1'b1);
        check_counters("disabled");
        apb(1'b1, OFF_CTRL, 32'h0000_0001);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("status enabled", 32'h1, rd);
        end_sim();
    end
endmodule // eth_tx_statistics_counters_tb
